// file: hdl/tcic_pkg.sv
// Constants, register indices and types of the timer capture block.
// Assumes a word-addressed bus slave: register index = Avalon word address.
package tcic_pkg;

    // Register indices (byte address on the bus is four times the index)
    localparam logic [15:0] ADDR_PIN_LEVEL  = 16'h1000;
    localparam logic [15:0] ADDR_PORT_DIR   = 16'h1001;
    localparam logic [15:0] ADDR_OC1_MASK   = 16'h100c;
    localparam logic [15:0] ADDR_CMP_LEVEL  = 16'h100d;
    localparam logic [15:0] ADDR_COUNT_HI   = 16'h100e;
    localparam logic [15:0] ADDR_COUNT_LO   = 16'h100f;
    localparam logic [15:0] ADDR_CAP1_HI    = 16'h1010;
    localparam logic [15:0] ADDR_CAP1_LO    = 16'h1011;
    localparam logic [15:0] ADDR_CAP2_HI    = 16'h1012;
    localparam logic [15:0] ADDR_CAP2_LO    = 16'h1013;
    localparam logic [15:0] ADDR_CAP3_HI    = 16'h1014;
    localparam logic [15:0] ADDR_CAP3_LO    = 16'h1015;
    localparam logic [15:0] ADDR_CH4_HI     = 16'h101e;
    localparam logic [15:0] ADDR_CH4_LO     = 16'h101f;
    localparam logic [15:0] ADDR_EDGE_CTRL  = 16'h1021;
    localparam logic [15:0] ADDR_MASK       = 16'h1022;
    localparam logic [15:0] ADDR_FLAG       = 16'h1023;
    localparam logic [15:0] ADDR_PRESCALE   = 16'h1024;
    localparam logic [15:0] ADDR_CMP_PIN_EN = 16'h1025;
    localparam logic [15:0] ADDR_PACC_CTRL  = 16'h1026;

    localparam logic [3:0][15:0] CAP_HI_ADDR =
        {ADDR_CH4_HI, ADDR_CAP3_HI, ADDR_CAP2_HI, ADDR_CAP1_HI};
    localparam logic [3:0][15:0] CAP_LO_ADDR =
        {ADDR_CH4_LO, ADDR_CAP3_LO, ADDR_CAP2_LO, ADDR_CAP1_LO};

    // Reset values
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] RST_CH4   = 16'hffff;
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [1:0]  RST_PRESC = 2'h0;
    localparam logic [15:0] COUNT_MAX = 16'hffff;

    // Field positions
    localparam int CH4_SEL_BIT  = 2;
    localparam int OVF_FLAG_BIT = 7;
    localparam int CH4_FLAG_BIT = 3;
    localparam int SHARED_PIN   = 3;
    localparam int NUM_CH       = 4;

    // Per channel: low bit of its edge pair and the port pin it watches
    localparam logic [3:0][2:0] EDGE_POS = {3'h6, 3'h0, 3'h2, 3'h4};
    localparam logic [3:0][1:0] CAP_PIN  = {2'h3, 2'h0, 2'h1, 2'h2};

    // Divider tap masks for divide by 1, 4, 8, 16
    localparam logic [3:0][3:0] PRESCALE_MASK = {4'hf, 4'h7, 4'h3, 4'h0};

    typedef enum logic [1:0] {
        EDGE_OFF  = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_ANY  = 2'b11
    } tcic_edge_t;

endpackage : tcic_pkg

// file: hdl/tcic_capture_timer.sv
// Free-running 16-bit timer with prescaler and four input capture channels.
// Assumes an Avalon-MM master on clk and asynchronous port pins on pa_in.
// Function
// - Counter ticks at clock divided by 1, 4, 8 or 16 per select code.
// - Counter starts at zero after reset and increments on each tick.
// - Past maximum the counter wraps to zero, sets overflow flag, keeps counting.
// - Software has no way to load, clear or stop the counter.
// - Three capture channels, four compares, one shared capture/compare channel.
// - A selected edge latches the counter into that channel's capture register.
// - Pin edges are synchronised; latch takes the stable pre-increment count.
// - Counter moves into the capture register as one 16-bit transfer.
// - Capture registers are not reset and read as two read-only bytes.
// - High byte read blocks capture transfer into that register for three cycles.
// - A capture arriving while blocked is held and written in the first unblocked cycle, unless a fresh edge in that cycle replaces it.
// - Each channel detects rising, falling, both edges, or is disabled.
// - Edge control pairs: ch4 7:6, ch1 5:4, ch2 3:2, ch3 1:0, reset zero.
// - Channels are independent; same-period edges capture identical counts.
// - Shared pin 3 is fourth capture only when ch4 select set; reset clear.
// - With pin 3 output and ch4 capture on, software pin writes cause captures.
// - Writes to the shared channel 4 register are ignored while it captures.
// - Levels on pins 3 to 0 are always readable in the pin level register.
// - Pins owned by compares ignore software port data writes.
// - First compare may drive any of pins 7 to 3; others own one pin each.
module tcic_capture_timer (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [7:0]  pa_in,
    output logic      [7:3]  pa_out,
    output logic      [7:3]  pa_oe,
    output logic             irq
);

    logic                   wait_ff;
    logic [7:0]             rdata_ff;
    logic [7:0]             rd_mux;
    logic                   acc;
    logic                   wr;
    logic                   rd;
    logic [7:0]             wbyte;

    logic [3:0]             div_ff;
    logic [1:0]             prescale_ff;
    logic                   tick;
    logic [15:0]            cnt_ff;
    logic                   ovf_evt;

    logic [7:0]             edge_ff;
    logic [7:0]             pacc_ff;
    logic [7:0]             dir_ff;
    logic [7:0]             port_ff;
    logic [7:0]             oc1m_ff;
    logic [7:0]             cmp_en_ff;
    logic [7:0]             cmp_lvl_ff;
    logic [7:0]             mask_ff;
    logic [7:0]             flag_ff;
    logic [7:0]             nxt_flag;
    logic                   irq_ff;
    logic                   ch4_sel;

    logic [7:0]             sync1_ff;
    logic [7:0]             sync2_ff;
    logic [7:0]             prev_ff;
    logic [7:0]             pin_src;

    logic [3:0]             cap_evt;
    logic [3:0]             hi_rd;
    logic [3:0]             block_ff;
    logic [3:0]             block2_ff;
    logic [3:0]             blocked;
    logic [3:0]             pend_ff;
    logic [3:0][15:0]       pend_val_ff;
    logic [3:0]             cap_wr;
    logic [3:0][15:0]       cap_nxt;
    logic [2:0][15:0]       cap_ff;
    logic [15:0]            ch4_ff;
    logic [3:0][15:0]       cap_val;
    logic                   cmp5_evt;

    logic [7:3]             pa_out_ff;
    logic [7:3]             pa_oe_ff;
    logic [7:3]             owned;

    assign acc     = (avs_read | avs_write) & ~wait_ff;
    assign wr      = acc & avs_write & avs_byteenable[0];
    // A read is taken, and its data latched, in its wait cycle
    assign rd      = avs_read & wait_ff;
    assign wbyte   = avs_writedata[7:0];
    assign ch4_sel = pacc_ff[tcic_pkg::CH4_SEL_BIT];

    assign avs_readdata    = {24'h000000, rdata_ff};
    assign avs_waitrequest = wait_ff;
    assign pa_out          = pa_out_ff;
    assign pa_oe           = pa_oe_ff;
    assign irq             = irq_ff;

    // One wait cycle per access: read data is latched in the wait cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_ff <= 1'b1;
        end else if (avs_read | avs_write) begin
            wait_ff <= ~wait_ff;
        end else begin
            wait_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= tcic_pkg::RST_BYTE;
        end else if (rd) begin
            rdata_ff <= rd_mux;
        end
    end

    always_comb begin
        case (avs_address)
            tcic_pkg::ADDR_PIN_LEVEL:  rd_mux = sync2_ff;
            tcic_pkg::ADDR_PORT_DIR:   rd_mux = dir_ff;
            tcic_pkg::ADDR_OC1_MASK:   rd_mux = oc1m_ff;
            tcic_pkg::ADDR_CMP_LEVEL:  rd_mux = cmp_lvl_ff;
            tcic_pkg::ADDR_COUNT_HI:   rd_mux = cnt_ff[15:8];
            tcic_pkg::ADDR_COUNT_LO:   rd_mux = cnt_ff[7:0];
            tcic_pkg::ADDR_CAP1_HI:    rd_mux = cap_val[0][15:8];
            tcic_pkg::ADDR_CAP1_LO:    rd_mux = cap_val[0][7:0];
            tcic_pkg::ADDR_CAP2_HI:    rd_mux = cap_val[1][15:8];
            tcic_pkg::ADDR_CAP2_LO:    rd_mux = cap_val[1][7:0];
            tcic_pkg::ADDR_CAP3_HI:    rd_mux = cap_val[2][15:8];
            tcic_pkg::ADDR_CAP3_LO:    rd_mux = cap_val[2][7:0];
            tcic_pkg::ADDR_CH4_HI:     rd_mux = cap_val[3][15:8];
            tcic_pkg::ADDR_CH4_LO:     rd_mux = cap_val[3][7:0];
            tcic_pkg::ADDR_EDGE_CTRL:  rd_mux = edge_ff;
            tcic_pkg::ADDR_MASK:       rd_mux = mask_ff;
            tcic_pkg::ADDR_FLAG:       rd_mux = flag_ff;
            tcic_pkg::ADDR_PRESCALE:   rd_mux = {6'h00, prescale_ff};
            tcic_pkg::ADDR_CMP_PIN_EN: rd_mux = cmp_en_ff;
            tcic_pkg::ADDR_PACC_CTRL:  rd_mux = pacc_ff;
            default:                   rd_mux = 8'h00;
        endcase
    end

    // Prescaler: free-running divider, tick when the selected taps are all ones
    always_ff @(posedge clk) begin
        if (rst) begin
            div_ff <= 4'h0;
        end else begin
            div_ff <= div_ff + 4'h1;
        end
    end

    assign tick = (div_ff & tcic_pkg::PRESCALE_MASK[prescale_ff])
                  == tcic_pkg::PRESCALE_MASK[prescale_ff];

    // No bus path reaches the counter; only reset and the tick move it
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= tcic_pkg::RST_COUNT;
        end else if (tick) begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end

    assign ovf_evt = tick & (cnt_ff == tcic_pkg::COUNT_MAX);

    // Software control registers
    always_ff @(posedge clk) begin
        if (rst) begin
            prescale_ff <= tcic_pkg::RST_PRESC;
            edge_ff     <= tcic_pkg::RST_BYTE;
            pacc_ff     <= tcic_pkg::RST_BYTE;
            dir_ff      <= tcic_pkg::RST_BYTE;
            port_ff     <= tcic_pkg::RST_BYTE;
            oc1m_ff     <= tcic_pkg::RST_BYTE;
            cmp_en_ff   <= tcic_pkg::RST_BYTE;
            cmp_lvl_ff  <= tcic_pkg::RST_BYTE;
            mask_ff     <= tcic_pkg::RST_BYTE;
        end else if (wr) begin
            case (avs_address)
                tcic_pkg::ADDR_PRESCALE:   prescale_ff <= wbyte[1:0];
                tcic_pkg::ADDR_EDGE_CTRL:  edge_ff     <= wbyte;
                tcic_pkg::ADDR_PACC_CTRL:  pacc_ff     <= wbyte;
                tcic_pkg::ADDR_PORT_DIR:   dir_ff      <= wbyte;
                tcic_pkg::ADDR_PIN_LEVEL:  port_ff     <= wbyte;
                tcic_pkg::ADDR_OC1_MASK:   oc1m_ff     <= {wbyte[7:3], 3'h0};
                tcic_pkg::ADDR_CMP_PIN_EN: cmp_en_ff   <= {1'b0, wbyte[6:3], 3'h0};
                tcic_pkg::ADDR_CMP_LEVEL:  cmp_lvl_ff  <= {wbyte[7:3], 3'h0};
                tcic_pkg::ADDR_MASK:       mask_ff     <= wbyte;
                default: begin
                end
            endcase
        end
    end

    // Pin 3 driven by software is fed back so its own edges can capture
    always_comb begin
        pin_src = pa_in;
        if (dir_ff[tcic_pkg::SHARED_PIN]) begin
            pin_src[tcic_pkg::SHARED_PIN] = pa_out_ff[tcic_pkg::SHARED_PIN];
        end
    end

    // Two-stage synchroniser, then a history stage for edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
            prev_ff  <= 8'h00;
        end else begin
            sync1_ff <= pin_src;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < tcic_pkg::NUM_CH; gi++) begin : gen_ch
            localparam int EP = int'(tcic_pkg::EDGE_POS[gi]);
            localparam int PN = int'(tcic_pkg::CAP_PIN[gi]);
            tcic_pkg::tcic_edge_t mode;
            logic                 rise;
            logic                 fall;
            logic                 on;

            assign mode = tcic_pkg::tcic_edge_t'(edge_ff[EP+1:EP]);
            assign rise = sync2_ff[PN] & ~prev_ff[PN];
            assign fall = ~sync2_ff[PN] & prev_ff[PN];
            assign on   = (gi != tcic_pkg::NUM_CH - 1) || ch4_sel;
            assign cap_evt[gi] = on & (((mode == tcic_pkg::EDGE_RISE) & rise)
                                    | ((mode == tcic_pkg::EDGE_FALL) & fall)
                                    | ((mode == tcic_pkg::EDGE_ANY) & (rise | fall)));
            // Block from the high-byte take until a back-to-back low read is latched
            assign hi_rd[gi]   = rd & (avs_address == tcic_pkg::CAP_HI_ADDR[gi]);
            assign blocked[gi] = hi_rd[gi] | block_ff[gi] | block2_ff[gi];
            // Fresh event wins over a held one: it is the newer time
            assign cap_wr[gi]  = ~blocked[gi] & (cap_evt[gi] | pend_ff[gi]);
            assign cap_nxt[gi] = cap_evt[gi] ? cnt_ff : pend_val_ff[gi];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            block_ff  <= 4'h0;
            block2_ff <= 4'h0;
            pend_ff   <= 4'h0;
        end else begin
            block_ff  <= hi_rd;
            block2_ff <= block_ff;
            for (int i = 0; i < tcic_pkg::NUM_CH; i++) begin
                if (cap_evt[i] & blocked[i]) begin
                    pend_ff[i] <= 1'b1;
                end else if (cap_wr[i]) begin
                    pend_ff[i] <= 1'b0;
                end
            end
        end
    end

    // Held times carry no reset value; pend_ff guards their use
    always_ff @(posedge clk) begin
        for (int i = 0; i < tcic_pkg::NUM_CH; i++) begin
            if (cap_evt[i] & blocked[i]) begin
                pend_val_ff[i] <= cnt_ff;
            end
        end
    end

    // Capture registers keep their contents through reset
    always_ff @(posedge clk) begin
        for (int i = 0; i < tcic_pkg::NUM_CH - 1; i++) begin
            if (cap_wr[i]) begin
                cap_ff[i] <= cap_nxt[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ch4_ff <= tcic_pkg::RST_CH4;
        end else if (cap_wr[3]) begin
            ch4_ff <= cap_nxt[3];
        end else if (wr & ~ch4_sel & (avs_address == tcic_pkg::ADDR_CH4_HI)) begin
            ch4_ff[15:8] <= wbyte;
        end else if (wr & ~ch4_sel & (avs_address == tcic_pkg::ADDR_CH4_LO)) begin
            ch4_ff[7:0] <= wbyte;
        end
    end

    assign cap_val  = {ch4_ff, cap_ff[2], cap_ff[1], cap_ff[0]};
    assign cmp5_evt = ~ch4_sel & tick & (cnt_ff == ch4_ff);

    // Flags: write one to clear; a same-cycle hardware set wins
    always_comb begin
        nxt_flag = flag_ff;
        if (wr && (avs_address == tcic_pkg::ADDR_FLAG)) begin
            nxt_flag = flag_ff & ~wbyte;
        end
        nxt_flag[2:0] = nxt_flag[2:0] | cap_evt[2:0];
        nxt_flag[tcic_pkg::CH4_FLAG_BIT] = nxt_flag[tcic_pkg::CH4_FLAG_BIT]
                                           | cap_evt[3] | cmp5_evt;
        nxt_flag[tcic_pkg::OVF_FLAG_BIT] = nxt_flag[tcic_pkg::OVF_FLAG_BIT]
                                           | ovf_evt;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_ff <= tcic_pkg::RST_BYTE;
            irq_ff  <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
            irq_ff  <= |(flag_ff & mask_ff);
        end
    end

    // Pin ownership: first compare by mask on 7..3, others one pin each
    always_comb begin
        for (int k = 3; k <= 7; k++) begin
            owned[k] = oc1m_ff[k] | cmp_en_ff[k];
        end
        owned[tcic_pkg::SHARED_PIN] = oc1m_ff[tcic_pkg::SHARED_PIN]
            | (cmp_en_ff[tcic_pkg::SHARED_PIN] & ~ch4_sel);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pa_out_ff <= 5'h00;
            pa_oe_ff  <= 5'h00;
        end else begin
            for (int k = 3; k <= 7; k++) begin
                pa_out_ff[k] <= owned[k] ? cmp_lvl_ff[k] : port_ff[k];
                pa_oe_ff[k]  <= owned[k] | dir_ff[k];
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_blocked_hit;
        cap_evt[0] && blocked[0];
    endsequence

    sequence s_quiet;
        !cap_evt[0] && !blocked[0];
    endsequence

    chk_count_step: assert property (tick && cnt_ff != 16'hffff
        |=> cnt_ff == $past(cnt_ff) + 16'h0001)
        else $error("counter did not step on tick");
    chk_count_wrap: assert property (tick && cnt_ff == 16'hffff
        |=> cnt_ff == 16'h0000 && flag_ff[7])
        else $error("counter wrap or overflow flag wrong");
    chk_count_hold: assert property (!tick |=> $stable(cnt_ff))
        else $error("counter moved without a tick");
    chk_div_four_spacing: assert property (tick && prescale_ff == 2'h1
        |=> (!tick || prescale_ff != 2'h1) [*3] ##1 (tick || prescale_ff != 2'h1))
        else $error("divide by four spacing wrong");
    chk_capture_value: assert property (cap_evt[1] && !blocked[1]
        |=> cap_val[1] == $past(cnt_ff))
        else $error("capture did not take the count");
    chk_block_holds: assert property (s_blocked_hit |=> $stable(cap_val[0]))
        else $error("capture written while blocked");
    chk_late_write: assert property (s_blocked_hit ##1 s_quiet
        |=> cap_val[0] == $past(cnt_ff, 2))
        else $error("held capture lost");
    chk_edge_off: assert property (edge_ff[5:4] == 2'b00 |-> !cap_evt[0])
        else $error("disabled channel captured");
    chk_ch4_write_lock: assert property (ch4_sel && !cap_wr[3]
        |=> $stable(ch4_ff))
        else $error("shared register changed in capture mode");
    chk_flag_irq: assert property (cap_evt[2] && mask_ff[2]
        |=> flag_ff[2] ##1 irq_ff)
        else $error("capture flag or interrupt missing");
    chk_owned_pin: assert property (cmp_en_ff[6] && !oc1m_ff[6]
        |=> pa_out_ff[6] == $past(cmp_lvl_ff[6]))
        else $error("owned pin followed port data");

endmodule : tcic_capture_timer

// file: testbench/tcic_pin_model.sv
// External signal sources on the port pins of the capture timer.
// Assumes the block owns pins 7:3 while their enable is high.
module tcic_pin_model (
    input  wire logic [7:0] ext_level,
    input  wire logic [7:3] pa_out,
    input  wire logic [7:3] pa_oe,
    output logic      [7:0] pa_in
);
    // A pin the block drives shows the block's level, so own writes loop back
    always_comb begin
        pa_in[2:0] = ext_level[2:0];
        for (int i = 3; i < 8; i++) begin
            pa_in[i] = pa_oe[i] ? pa_out[i] : ext_level[i];
        end
    end
endmodule : tcic_pin_model

// file: testbench/timer_counter_input_capture_test.sv
// Self-checking bench of the capture timer: bus tasks, pin stimulus, checks.
// Assumes the pin model resolves the shared pins.
module timer_counter_input_capture_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk;
    logic        rst;
    logic [15:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  pa_in;
    logic [7:3]  pa_out;
    logic [7:3]  pa_oe;
    logic        irq;
    logic [7:0]  ext_level;
    logic [31:0] rng = 32'h1d;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          div_tab [4] = '{1, 4, 8, 16};
    int          edge_pos [3] = '{4, 2, 0};

    tcic_capture_timer i_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pa_in(pa_in), .pa_out(pa_out),
        .pa_oe(pa_oe), .irq(irq));
    tcic_pin_model i_pins (.ext_level(ext_level), .pa_out(pa_out), .pa_oe(pa_oe),
        .pa_in(pa_in));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // Flag expected from channel k in edge mode m after a rise or fall on its pin
    function automatic logic [15:0] exp_flag(input int k, input int m, input int fall);
        return ((fall == 0 && m[0]) || (fall == 1 && m[1])) ? 16'(1 << k) : 16'h0000;
    endfunction : exp_flag

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_eq

    task automatic check_range(input logic [15:0] got, input logic [15:0] lo,
                               input logic [15:0] hi);
        checks_done++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask : check_range

    // One Avalon transfer; the request stands until waitrequest is sampled low
    task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] wd,
                       output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_read <= ~w;
        avs_write <= w;
        avs_writedata <= {24'h000000, wd};
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            final_report();
        end
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] x;
        bus(a, 1'b1, d, x);
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        bus(a, 1'b0, 8'h00, d);
    endtask : rd

    // High byte first, then low at once, so the pair reads coherent
    task automatic rd16(input logic [15:0] a, output logic [15:0] d);
        rd(a, d[15:8]);
        rd(a + 16'h0001, d[7:0]);
    endtask : rd16

    initial begin
        logic [7:0]  b;
        logic [15:0] c0;
        logic [15:0] c1;
        logic [15:0] c2;
        int          t0;
        rst = 1'b1;
        avs_address = 16'h0000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hf;
        ext_level = 8'h00;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(tcic_pkg::ADDR_EDGE_CTRL, b);
        check_eq({8'h00, b}, 16'h0000);
        rd16(tcic_pkg::ADDR_CH4_HI, c0);
        check_eq(c0, tcic_pkg::RST_CH4);
        rd16(tcic_pkg::ADDR_COUNT_HI, c0);
        check_range(c0, 16'h0000, 16'h0020);
        rd(16'h1030, b);
        check_eq({8'h00, b}, 16'h0000);
        $display("test reset done");
        for (int p = 0; p < 4; p++) begin
            wr(tcic_pkg::ADDR_PRESCALE, 8'(p));
            rd(tcic_pkg::ADDR_COUNT_LO, c0[7:0]);
            t0 = cyc;
            repeat (64) @(posedge clk);
            rd(tcic_pkg::ADDR_COUNT_LO, b);
            t0 = (cyc - t0) / div_tab[p];
            check_range(16'(8'(b - c0[7:0])), 16'(t0 - 1), 16'(t0 + 1));
        end
        $display("test prescale done");
        wr(tcic_pkg::ADDR_PRESCALE, 8'h00);
        for (int k = 0; k < 3; k++) begin
            for (int m = 0; m < 4; m++) begin
                wr(tcic_pkg::ADDR_EDGE_CTRL, 8'(m << edge_pos[k]));
                wr(tcic_pkg::ADDR_FLAG, 8'hff);
                for (int f = 0; f < 2; f++) begin
                    @(posedge clk);
                    ext_level[2:0] <= (f == 0) ? 3'h7 : 3'h0;
                    repeat (5) @(posedge clk);
                    rd(tcic_pkg::ADDR_FLAG, b);
                    check_eq({13'h0000, b[2:0]}, exp_flag(k, m, f));
                    wr(tcic_pkg::ADDR_FLAG, 8'hff);
                end
            end
        end
        $display("test edge modes done");
        wr(tcic_pkg::ADDR_EDGE_CTRL, 8'h3c);
        rd(tcic_pkg::ADDR_COUNT_LO, b);
        @(posedge clk);
        ext_level[2:1] <= 2'h3;
        repeat (5) @(posedge clk);
        rd16(tcic_pkg::ADDR_CAP1_HI, c1);
        rd16(tcic_pkg::ADDR_CAP2_HI, c2);
        check_range(16'(8'(c1[7:0] - b)), 16'h0000, 16'h0010);
        check_eq(c2, c1);
        for (int i = 0; i < 6; i++) begin
            rng = xs(rng);
            fork
                begin
                    repeat (rng[1:0]) @(posedge clk);
                    ext_level[2] <= ~ext_level[2];
                end
                rd16(tcic_pkg::ADDR_CAP1_HI, c0);
            join
            repeat (5) @(posedge clk);
            rd16(tcic_pkg::ADDR_CAP1_HI, c2);
            check_eq(c0, (c0 === c1) ? c1 : c2);
            check_eq({15'h0000, c2 !== c1}, 16'h0001);
            c1 = c2;
        end
        $display("test capture done");
        for (int i = 0; i < 4; i++) begin
            rng = xs(rng);
            @(posedge clk);
            ext_level[3:0] <= rng[3:0];
            repeat (4) @(posedge clk);
            rd(tcic_pkg::ADDR_PIN_LEVEL, b);
            check_eq({12'h000, b[3:0]}, {12'h000, rng[3:0]});
        end
        wr(tcic_pkg::ADDR_CH4_HI, 8'h12);
        rd(tcic_pkg::ADDR_CH4_HI, b);
        check_eq({8'h00, b}, 16'h0012);
        wr(tcic_pkg::ADDR_PACC_CTRL, 8'h04);
        wr(tcic_pkg::ADDR_CH4_HI, 8'h34);
        rd(tcic_pkg::ADDR_CH4_HI, b);
        check_eq({8'h00, b}, 16'h0012);
        wr(tcic_pkg::ADDR_PORT_DIR, 8'h08);
        wr(tcic_pkg::ADDR_EDGE_CTRL, 8'h40);
        wr(tcic_pkg::ADDR_FLAG, 8'hff);
        wr(tcic_pkg::ADDR_PIN_LEVEL, 8'h08);
        repeat (5) @(posedge clk);
        rd(tcic_pkg::ADDR_FLAG, b);
        check_eq({15'h0000, b[3]}, 16'h0001);
        wr(tcic_pkg::ADDR_PORT_DIR, 8'h00);
        $display("test shared channel done");
        wr(tcic_pkg::ADDR_EDGE_CTRL, 8'h03);
        wr(tcic_pkg::ADDR_FLAG, 8'hff);
        wr(tcic_pkg::ADDR_MASK, 8'h04);
        @(posedge clk);
        ext_level[0] <= ~ext_level[0];
        repeat (6) @(posedge clk);
        check_eq({15'h0000, irq}, 16'h0001);
        wr(tcic_pkg::ADDR_FLAG, 8'h04);
        repeat (2) @(posedge clk);
        check_eq({15'h0000, irq}, 16'h0000);
        wr(tcic_pkg::ADDR_CMP_LEVEL, 8'hc0);
        wr(tcic_pkg::ADDR_CMP_PIN_EN, 8'h40);
        wr(tcic_pkg::ADDR_PIN_LEVEL, 8'h00);
        repeat (2) @(posedge clk);
        check_eq({11'h000, pa_out}, 16'h0008);
        check_eq({11'h000, pa_oe}, 16'h0008);
        wr(tcic_pkg::ADDR_OC1_MASK, 8'h80);
        repeat (2) @(posedge clk);
        check_eq({11'h000, pa_out}, 16'h0018);
        check_eq({11'h000, pa_oe}, 16'h0018);
        $display("test irq and pins done");
        rd16(tcic_pkg::ADDR_COUNT_HI, c0);
        wr(tcic_pkg::ADDR_COUNT_HI, 8'h00);
        wr(tcic_pkg::ADDR_COUNT_LO, 8'h00);
        rd16(tcic_pkg::ADDR_COUNT_HI, c1);
        check_range({8'h00, c1[15:8]}, {8'h00, c0[15:8]}, {8'h00, c0[15:8]} + 16'h1);
        wr(tcic_pkg::ADDR_FLAG, 8'hff);
        rd16(tcic_pkg::ADDR_COUNT_HI, c0);
        // Margin covers a low-byte carry between the two byte reads
        repeat (int'(tcic_pkg::COUNT_MAX - c0) - 300) @(posedge clk);
        rd(tcic_pkg::ADDR_FLAG, b);
        check_eq({15'h0000, b[7]}, 16'h0000);
        repeat (600) @(posedge clk);
        rd(tcic_pkg::ADDR_FLAG, b);
        check_eq({15'h0000, b[7]}, 16'h0001);
        rd16(tcic_pkg::ADDR_COUNT_HI, c1);
        check_range(c1, tcic_pkg::RST_COUNT, 16'h0400);
        $display("test overflow done");
        final_report();
    end
endmodule : timer_counter_input_capture_test
